/* File: core/crs_cfg.svh */
// Overview of operation
// - Four 16-bit general registers serve as transfer, arithmetic and logic operands.
// - General words 0 and 1 split into separately writable high and low bytes.
// - Word 2 over word 0 forms one long; word 3 over word 1 likewise.
// - Two 16-bit address registers give indirect/relative addresses and act as operands.
// - Both address registers form one 32-bit register, second one in the upper half.
// - A 16-bit frame base register holds the frame-relative addressing base.
// - A 20-bit vector table base register holds the interrupt table start.
// - A 20-bit program counter holds the address of the next fetched instruction.
// - Separate user and interrupt stack pointers; stack-select flag picks the active one.
// - A 16-bit static base register holds the static-relative addressing base.
// - An 11-bit flag register reflects processor state and holds all flags.
// - Carry flag captures carry, borrow or shifted-out bit of each ALU operation.
// - After arithmetic, zero flag is 1 for a zero result, else 0.
// - After arithmetic, sign flag is 1 for a negative result, else 0.
// - Bank-select flag 0 picks register bank 0, 1 picks bank 1.
// - Overflow flag is 1 when an operation overflows, else 0.
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ==========================================================
// Flag register layout
`define CRS_FLG_W       11
`define CRS_FLG_C       0
`define CRS_FLG_D       1
`define CRS_FLG_Z       2
`define CRS_FLG_S       3
`define CRS_FLG_B       4
`define CRS_FLG_O       5
`define CRS_FLG_I       6
`define CRS_FLG_U       7

// ==========================================================
// Widths, map and reset values
`define CRS_WORD_W      16
`define CRS_DATA_W      32
`define CRS_PADDR_W     12
`define CRS_IDX_LSB     2
`define CRS_IDX_MSB     5
`define CRS_STRB_LOW    4'h1
`define CRS_STRB_HIGH   4'h2
`define CRS_RST_WORD    16'h0000
`define CRS_RST_FLG     11'h000
`define CRS_RST_DATA    32'h0000_0000

`endif

/* File: core/crs_pkg.sv */
package crs_pkg;

    // Register selector; APB word index equals the selector value
    typedef enum logic [3:0] {
        CRS_SEL_GW0   = 4'h0,
        CRS_SEL_GW1   = 4'h1,
        CRS_SEL_GW2   = 4'h2,
        CRS_SEL_GW3   = 4'h3,
        CRS_SEL_AW0   = 4'h4,
        CRS_SEL_AW1   = 4'h5,
        CRS_SEL_FB    = 4'h6,
        CRS_SEL_SB    = 4'h7,
        CRS_SEL_VTB   = 4'h8,
        CRS_SEL_USP   = 4'h9,
        CRS_SEL_ISP   = 4'hA,
        CRS_SEL_FLG   = 4'hB,
        CRS_SEL_PC    = 4'hC,
        CRS_SEL_GLOW  = 4'hD,
        CRS_SEL_GHIGH = 4'hE,
        CRS_SEL_ALONG = 4'hF
    } crs_reg_e;

    typedef enum logic [1:0] {
        CRS_SZ_BYTE = 2'h0,
        CRS_SZ_WORD = 2'h1,
        CRS_SZ_LONG = 2'h2
    } crs_size_e;

endpackage : crs_pkg

/* File: core/crs_register_set.sv */
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "crs_cfg.svh"

module crs_register_set
    import crs_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`CRS_PADDR_W-1:0] paddr,
    input  wire logic [`CRS_DATA_W-1:0] pwdata,
    input  wire logic [3:0]             pstrb,
    output logic                        pready,
    output logic [`CRS_DATA_W-1:0]      prdata,
    output logic                        pslverr,
    // Datapath register write
    input  wire logic                   dpWrEn,
    input  wire crs_reg_e               dpWrSel,
    input  wire crs_size_e              dpWrSize,
    input  wire logic                   dpWrHigh,
    input  wire logic [`CRS_DATA_W-1:0] dpWrData,
    // Datapath register read
    input  wire crs_reg_e               dpRdSel,
    output logic [`CRS_DATA_W-1:0]      dpRdData,
    // Datapath active stack pointer write
    input  wire logic                   dpSpWrEn,
    input  wire logic [`CRS_WORD_W-1:0] dpSpWrData,
    // Program counter advance
    input  wire logic                   pcStepEn,
    input  wire logic [2:0]             pcStep,
    // ALU flag update
    input  wire logic                   aluValid,
    input  wire logic                   aluArith,
    input  wire logic                   aluCarryEn,
    input  wire logic                   aluCarry,
    input  wire logic                   aluOverflowEn,
    input  wire logic                   aluOverflow,
    input  wire crs_size_e              aluSize,
    input  wire logic [`CRS_DATA_W-1:0] aluResult,
    // Core state
    output logic [ADDR_W-1:0]           nextFetchPointer,
    output logic [ADDR_W-1:0]           vectorTableBase,
    output logic [`CRS_FLG_W-1:0]       cpuStateFlags,
    output logic [`CRS_WORD_W-1:0]      activeStackPointer
);

    initial begin
        if (ADDR_W < `CRS_WORD_W + 1 || ADDR_W > `CRS_DATA_W) begin
            $error("crs_register_set: ADDR_W out of range");
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic resultZero(input logic [`CRS_DATA_W-1:0] r, input crs_size_e s);
        case (s)
            CRS_SZ_BYTE: resultZero = (r[7:0] == 8'h00);
            CRS_SZ_WORD: resultZero = (r[15:0] == 16'h0000);
            default:     resultZero = (r == `CRS_RST_DATA);
        endcase
    endfunction : resultZero

    function automatic logic resultNeg(input logic [`CRS_DATA_W-1:0] r, input crs_size_e s);
        case (s)
            CRS_SZ_BYTE: resultNeg = r[7];
            CRS_SZ_WORD: resultNeg = r[15];
            default:     resultNeg = r[31];
        endcase
    endfunction : resultNeg

    // Byte write keeps the untouched half
    function automatic logic [15:0] mergeWord(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input crs_size_e   s,
                                              input logic        hi);
        if (s != CRS_SZ_BYTE) begin
            mergeWord = d[15:0];
        end else if (hi) begin
            mergeWord = {d[7:0], old[7:0]};
        end else begin
            mergeWord = {old[15:8], d[7:0]};
        end
    endfunction : mergeWord

    // ==========================================================
    // Storage
    logic [`CRS_WORD_W-1:0] genReg    [2][4];
    logic [`CRS_WORD_W-1:0] addrReg   [2][2];
    logic [`CRS_WORD_W-1:0] frameReg  [2];
    logic [`CRS_WORD_W-1:0] staticReg;
    logic [ADDR_W-1:0]      vtbReg;
    logic [ADDR_W-1:0]      pcReg;
    logic [`CRS_WORD_W-1:0] uspReg;
    logic [`CRS_WORD_W-1:0] uspNext;
    logic [`CRS_WORD_W-1:0] ispReg;
    logic [`CRS_WORD_W-1:0] ispNext;
    logic [`CRS_FLG_W-1:0]  flagsReg;
    logic [`CRS_FLG_W-1:0]  flagsNext;
    logic [`CRS_WORD_W-1:0] activeSpReg;
    logic                   preadyReg;
    logic                   pslverrReg;
    logic [`CRS_DATA_W-1:0] prdataReg;
    logic [`CRS_DATA_W-1:0] dpRdReg;
    logic                   bank;

    assign bank = flagsReg[`CRS_FLG_B];

    // ==========================================================
    // Read views of the selected bank
    logic [`CRS_DATA_W-1:0] view [16];

    always_comb begin
        view[CRS_SEL_GW0]   = {16'h0000, genReg[bank][0]};
        view[CRS_SEL_GW1]   = {16'h0000, genReg[bank][1]};
        view[CRS_SEL_GW2]   = {16'h0000, genReg[bank][2]};
        view[CRS_SEL_GW3]   = {16'h0000, genReg[bank][3]};
        view[CRS_SEL_AW0]   = {16'h0000, addrReg[bank][0]};
        view[CRS_SEL_AW1]   = {16'h0000, addrReg[bank][1]};
        view[CRS_SEL_FB]    = {16'h0000, frameReg[bank]};
        view[CRS_SEL_SB]    = {16'h0000, staticReg};
        view[CRS_SEL_VTB]   = `CRS_DATA_W'(vtbReg);
        view[CRS_SEL_USP]   = {16'h0000, uspReg};
        view[CRS_SEL_ISP]   = {16'h0000, ispReg};
        view[CRS_SEL_FLG]   = `CRS_DATA_W'(flagsReg);
        view[CRS_SEL_PC]    = `CRS_DATA_W'(pcReg);
        view[CRS_SEL_GLOW]  = {genReg[bank][2], genReg[bank][0]};
        view[CRS_SEL_GHIGH] = {genReg[bank][3], genReg[bank][1]};
        view[CRS_SEL_ALONG] = {addrReg[bank][1], addrReg[bank][0]};
    end

    // ==========================================================
    // APB decode
    crs_reg_e apbIdx;
    logic     apbHit;
    logic     apbErr;
    logic     apbCommit;

    always_comb begin
        apbIdx = crs_reg_e'(paddr[`CRS_IDX_MSB:`CRS_IDX_LSB]);
        apbHit = (paddr[`CRS_PADDR_W-1:`CRS_IDX_MSB+1] == '0);
        // Program counter only moves with execution
        apbErr = !apbHit || (pwrite && apbIdx == CRS_SEL_PC);
        apbCommit = psel && penable && preadyReg && pwrite && !pslverrReg;
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            preadyReg  <= 1'b0;
            pslverrReg <= 1'b0;
            prdataReg  <= `CRS_RST_DATA;
        end else if (psel && penable && !preadyReg) begin
            preadyReg  <= 1'b1;
            pslverrReg <= apbErr;
            prdataReg  <= (!pwrite && apbHit) ? view[apbIdx] : `CRS_RST_DATA;
        end else begin
            preadyReg  <= 1'b0;
            pslverrReg <= 1'b0;
        end
    end

    // ==========================================================
    // Write ports: 0 = APB, 1 = datapath (datapath wins on a clash)
    logic      wrEn   [2];
    crs_reg_e  wrSel  [2];
    crs_size_e wrSize [2];
    logic      wrHigh [2];
    logic [31:0] wrData [2];

    always_comb begin
        wrEn[0]   = apbCommit;
        wrSel[0]  = apbIdx;
        wrHigh[0] = (pstrb == `CRS_STRB_HIGH);
        wrSize[0] = (pstrb == `CRS_STRB_LOW || pstrb == `CRS_STRB_HIGH) ?
                    CRS_SZ_BYTE : CRS_SZ_WORD;
        wrData[0] = wrHigh[0] ? {24'h00_0000, pwdata[15:8]} : pwdata;
        wrEn[1]   = dpWrEn;
        wrSel[1]  = dpWrSel;
        wrSize[1] = dpWrSize;
        wrHigh[1] = dpWrHigh;
        wrData[1] = dpWrData;
    end

    // ==========================================================
    // Banked general, address and frame registers
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < 4; i++) begin
                    genReg[b][i] <= `CRS_RST_WORD;
                end
                addrReg[b][0] <= `CRS_RST_WORD;
                addrReg[b][1] <= `CRS_RST_WORD;
                frameReg[b]   <= `CRS_RST_WORD;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wrEn[p]) begin
                    case (wrSel[p])
                        CRS_SEL_GW0: begin
                            genReg[bank][0] <= mergeWord(genReg[bank][0], wrData[p],
                                                         wrSize[p], wrHigh[p]);
                        end
                        CRS_SEL_GW1: begin
                            genReg[bank][1] <= mergeWord(genReg[bank][1], wrData[p],
                                                         wrSize[p], wrHigh[p]);
                        end
                        CRS_SEL_GW2: genReg[bank][2] <= wrData[p][15:0];
                        CRS_SEL_GW3: genReg[bank][3] <= wrData[p][15:0];
                        CRS_SEL_AW0: addrReg[bank][0] <= wrData[p][15:0];
                        CRS_SEL_AW1: addrReg[bank][1] <= wrData[p][15:0];
                        CRS_SEL_FB:  frameReg[bank] <= wrData[p][15:0];
                        CRS_SEL_GLOW: begin
                            genReg[bank][0] <= wrData[p][15:0];
                            genReg[bank][2] <= wrData[p][31:16];
                        end
                        CRS_SEL_GHIGH: begin
                            genReg[bank][1] <= wrData[p][15:0];
                            genReg[bank][3] <= wrData[p][31:16];
                        end
                        CRS_SEL_ALONG: begin
                            addrReg[bank][0] <= wrData[p][15:0];
                            addrReg[bank][1] <= wrData[p][31:16];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Unbanked bases
    always_ff @(posedge clk) begin
        if (reset) begin
            staticReg <= `CRS_RST_WORD;
            vtbReg    <= ADDR_W'(`CRS_RST_DATA);
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wrEn[p] && wrSel[p] == CRS_SEL_SB) begin
                    staticReg <= wrData[p][15:0];
                end
                if (wrEn[p] && wrSel[p] == CRS_SEL_VTB) begin
                    vtbReg <= wrData[p][ADDR_W-1:0];
                end
            end
        end
    end

    // ==========================================================
    // Program counter
    always_ff @(posedge clk) begin
        if (reset) begin
            pcReg <= ADDR_W'(`CRS_RST_DATA);
        end else if (dpWrEn && dpWrSel == CRS_SEL_PC) begin
            pcReg <= dpWrData[ADDR_W-1:0];
        end else if (pcStepEn) begin
            pcReg <= pcReg + ADDR_W'(pcStep);
        end
    end

    // ==========================================================
    // Flags: register writes first, ALU outcome overrides
    always_comb begin
        flagsNext = flagsReg;
        for (int p = 0; p < 2; p++) begin
            if (wrEn[p] && wrSel[p] == CRS_SEL_FLG) begin
                // Debug bit stored as written; software must keep it clear
                flagsNext = wrData[p][`CRS_FLG_W-1:0];
            end
        end
        if (aluValid) begin
            if (aluCarryEn) begin
                flagsNext[`CRS_FLG_C] = aluCarry;
            end
            if (aluArith) begin
                flagsNext[`CRS_FLG_Z] = resultZero(aluResult, aluSize);
                flagsNext[`CRS_FLG_S] = resultNeg(aluResult, aluSize);
            end
            if (aluOverflowEn) begin
                flagsNext[`CRS_FLG_O] = aluOverflow;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flagsReg <= `CRS_RST_FLG;
        end else begin
            flagsReg <= flagsNext;
        end
    end

    // ==========================================================
    // Stack pointers; active one follows the stack-select flag
    always_comb begin
        uspNext = uspReg;
        ispNext = ispReg;
        for (int p = 0; p < 2; p++) begin
            if (wrEn[p] && wrSel[p] == CRS_SEL_USP) begin
                uspNext = wrData[p][15:0];
            end
            if (wrEn[p] && wrSel[p] == CRS_SEL_ISP) begin
                ispNext = wrData[p][15:0];
            end
        end
        // Push or pop lands on whichever pointer is active now
        if (dpSpWrEn) begin
            if (flagsReg[`CRS_FLG_U]) begin
                uspNext = dpSpWrData;
            end else begin
                ispNext = dpSpWrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            uspReg      <= `CRS_RST_WORD;
            ispReg      <= `CRS_RST_WORD;
            activeSpReg <= `CRS_RST_WORD;
        end else begin
            uspReg      <= uspNext;
            ispReg      <= ispNext;
            // Built from next values so the output never lags a flag flip
            activeSpReg <= flagsNext[`CRS_FLG_U] ? uspNext : ispNext;
        end
    end

    // ==========================================================
    // Datapath read port, one cycle latency
    always_ff @(posedge clk) begin
        if (reset) begin
            dpRdReg <= `CRS_RST_DATA;
        end else begin
            dpRdReg <= view[dpRdSel];
        end
    end

    // ==========================================================
    // Outputs
    assign pready             = preadyReg;
    assign pslverr            = pslverrReg;
    assign prdata             = prdataReg;
    assign dpRdData           = dpRdReg;
    assign nextFetchPointer   = pcReg;
    assign vectorTableBase    = vtbReg;
    assign cpuStateFlags      = flagsReg;
    assign activeStackPointer = activeSpReg;

endmodule : crs_register_set

/* File: bench/crs_register_set_checker.sv */
`timescale 1ns/10ps
`include "crs_cfg.svh"
// ====================
// Port checker
module crs_register_set_checker
    import crs_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    reset,
    // APB
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`CRS_PADDR_W-1:0] paddr,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // Datapath
    input wire logic                    dpWrEn,
    input wire crs_reg_e                dpWrSel,
    input wire logic                    pcStepEn,
    input wire logic [2:0]              pcStep,
    input wire logic                    aluValid,
    input wire logic                    aluArith,
    input wire logic                    aluCarryEn,
    input wire logic                    aluCarry,
    input wire logic                    aluOverflowEn,
    input wire logic                    aluOverflow,
    input wire crs_size_e               aluSize,
    input wire logic [`CRS_DATA_W-1:0]  aluResult,
    // Core state
    input wire logic [ADDR_W-1:0]       nextFetchPointer,
    input wire logic [`CRS_FLG_W-1:0]   cpuStateFlags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_take;
        psel && penable && !pready && paddr[1:0] == 2'b00;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_one_wait;
        s_take |=> s_answer;
    endproperty
    property p_unmapped;
        s_take ##0 paddr >= 12'h040 |=> pready && pslverr;
    endproperty
    property p_pc_readonly;
        s_take ##0 (pwrite && paddr == 12'h030) |=> pready && pslverr;
    endproperty
    property p_mapped_ok;
        s_take ##0 (paddr < 12'h040 && !(pwrite && paddr == 12'h030)) |=> !pslverr;
    endproperty
    // A datapath load of the counter outranks the step
    property p_pc_step;
        pcStepEn && !(dpWrEn && dpWrSel == CRS_SEL_PC) |=>
            nextFetchPointer == $past(nextFetchPointer) + $past(pcStep);
    endproperty
    property p_carry;
        aluValid && aluCarryEn |=> cpuStateFlags[`CRS_FLG_C] == $past(aluCarry);
    endproperty
    property p_zero;
        aluValid && aluArith && aluSize == CRS_SZ_WORD |=>
            cpuStateFlags[`CRS_FLG_Z] == (($past(aluResult) & 32'h0000_FFFF) == 32'h0);
    endproperty
    property p_sign;
        aluValid && aluArith && aluSize == CRS_SZ_WORD |=>
            cpuStateFlags[`CRS_FLG_S] == |($past(aluResult) & 32'h0000_8000);
    endproperty
    property p_overflow;
        aluValid && aluOverflowEn |=> cpuStateFlags[`CRS_FLG_O] == $past(aluOverflow);
    endproperty

    a_one_wait: assert property (p_one_wait)
        else $error("pready not one cycle after one wait state");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access without error");
    a_pc_readonly: assert property (p_pc_readonly)
        else $error("counter write not refused");
    a_mapped_ok: assert property (p_mapped_ok)
        else $error("error on a mapped access");
    a_pc_step: assert property (p_pc_step)
        else $error("counter did not advance by the step");
    a_carry: assert property (p_carry)
        else $error("carry flag wrong");
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");
    a_sign: assert property (p_sign)
        else $error("sign flag wrong");
    a_overflow: assert property (p_overflow)
        else $error("overflow flag wrong");
endmodule : crs_register_set_checker

bind crs_register_set crs_register_set_checker #(.ADDR_W(ADDR_W)) chk (.*);

/* File: bench/crs_datapath_model.sv */
`timescale 1ns/10ps
// ====================
// Decode and ALU side
module crs_datapath_model
    import crs_pkg::*;
(
    // Clock and read-back
    input  wire logic        clk,
    input  wire logic [31:0] dpRdData,
    // Register access
    output logic             dpWrEn,
    output crs_reg_e         dpWrSel,
    output crs_size_e        dpWrSize,
    output logic             dpWrHigh,
    output logic [31:0]      dpWrData,
    output crs_reg_e         dpRdSel,
    output logic             dpSpWrEn,
    output logic [15:0]      dpSpWrData,
    // Counter and ALU
    output logic             pcStepEn,
    output logic [2:0]       pcStep,
    output logic             aluValid,
    output logic             aluArith,
    output logic             aluCarryEn,
    output logic             aluCarry,
    output logic             aluOverflowEn,
    output logic             aluOverflow,
    output crs_size_e        aluSize,
    output logic [31:0]      aluResult
);
    initial begin
        {dpWrEn, dpWrHigh, dpSpWrEn, pcStepEn, aluValid, aluArith} = '0;
        {aluCarryEn, aluCarry, aluOverflowEn, aluOverflow} = '0;
        {dpWrData, aluResult, dpSpWrData, pcStep} = '0;
        dpWrSel = CRS_SEL_GW0;
        dpRdSel = CRS_SEL_GW0;
        dpWrSize = CRS_SZ_WORD;
        aluSize = CRS_SZ_WORD;
    end

    // Data inverted after each strobe except the counter step so a stale value never passes
    task automatic dpw(input crs_reg_e s, input crs_size_e z, input logic h,
                       input logic [31:0] d);
        @(posedge clk);
        dpWrEn <= 1'b1;
        dpWrSel <= s;
        dpWrSize <= z;
        dpWrHigh <= h;
        dpWrData <= d;
        @(posedge clk);
        dpWrEn <= 1'b0;
        dpWrData <= ~d;
    endtask : dpw

    task automatic spw(input logic [15:0] d);
        @(posedge clk);
        dpSpWrEn <= 1'b1;
        dpSpWrData <= d;
        @(posedge clk);
        dpSpWrEn <= 1'b0;
        dpSpWrData <= ~d;
    endtask : spw

    task automatic step(input logic [2:0] n);
        @(posedge clk);
        pcStepEn <= 1'b1;
        pcStep <= n;
        @(posedge clk);
        pcStepEn <= 1'b0;
    endtask : step

    task automatic alu(input logic ar, ce, c, oe, o, input crs_size_e z,
                       input logic [31:0] r);
        @(posedge clk);
        aluValid <= 1'b1;
        aluArith <= ar;
        aluCarryEn <= ce;
        aluCarry <= c;
        aluOverflowEn <= oe;
        aluOverflow <= o;
        aluSize <= z;
        aluResult <= r;
        @(posedge clk);
        aluValid <= 1'b0;
        aluResult <= ~r;
    endtask : alu

    task automatic rd(input crs_reg_e s, output logic [31:0] v);
        @(posedge clk);
        dpRdSel <= s;
        repeat (2) @(posedge clk);
        v = dpRdData;
    endtask : rd
endmodule : crs_datapath_model

/* File: bench/crs_register_set_bench.sv */
`timescale 1ns/10ps
// ====================
// Register set bench
module crs_register_set_bench;
    import crs_pkg::*;
    localparam int ADDR_W = 20;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, dpWrData, dpRdData, aluResult, rdat, d;
    logic dpWrEn, dpWrHigh, dpSpWrEn, pcStepEn, aluValid, aluArith;
    logic aluCarryEn, aluCarry, aluOverflowEn, aluOverflow;
    crs_reg_e dpWrSel, dpRdSel;
    crs_size_e dpWrSize, aluSize;
    logic [15:0] dpSpWrData, activeStackPointer;
    logic [2:0] pcStep;
    logic [ADDR_W-1:0] nextFetchPointer, vectorTableBase;
    logic [10:0] cpuStateFlags;
    int fail_count = 0;
    int num_checks = 0;

    crs_register_set #(.ADDR_W(ADDR_W)) dut (.*);
    crs_datapath_model dpm (.*);

    always #25 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            tally_and_finish();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 4'hF);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'hF);
        check(rdat, exp);
    endtask : rdchk

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 16; i++) rdchk(12'(i * 4), 32'h0000_0000);
        $display("test reset_values done");
        // Selectors 0 to 10 all written first so that aliasing between registers shows
        for (int i = 0; i < 11; i++) wr(12'(i * 4), 32'hABCD_0000 | 32'(i * 4369));
        for (int i = 0; i < 11; i++) begin
            d = (32'hABCD_0000 | 32'(i * 4369)) & (i == 8 ? 32'h000F_FFFF : 32'h0000_FFFF);
            rdchk(12'(i * 4), d);
        end
        check(32'(vectorTableBase), 32'h000D_8888);
        wr(12'h02C, 32'hFFFF_FFFD);
        rdchk(12'h02C, 32'h0000_07FD);
        wr(12'h02C, 32'h0000_0000);
        $display("test words done");
        wr(12'h034, 32'h1234_5678);
        rdchk(12'h000, 32'h0000_5678);
        rdchk(12'h008, 32'h0000_1234);
        wr(12'h038, 32'h9ABC_DEF0);
        rdchk(12'h004, 32'h0000_DEF0);
        rdchk(12'h00C, 32'h0000_9ABC);
        wr(12'h03C, 32'h0F1E_2D3C);
        rdchk(12'h010, 32'h0000_2D3C);
        rdchk(12'h014, 32'h0000_0F1E);
        dpm.rd(CRS_SEL_GW2, d);
        check(d, 32'h0000_1234);
        dpm.dpw(CRS_SEL_ALONG, CRS_SZ_LONG, 1'b0, 32'hCAFE_0001);
        rdchk(12'h03C, 32'hCAFE_0001);
        apb(1'b1, 12'h000, 32'h0000_00AB, 4'h1);
        rdchk(12'h000, 32'h0000_56AB);
        apb(1'b1, 12'h000, 32'h0000_CD00, 4'h2);
        rdchk(12'h000, 32'h0000_CDAB);
        $display("test pairs_bytes done");
        wr(12'h02C, 32'h0000_0010);
        wr(12'h000, 32'h0000_2222);
        rdchk(12'h000, 32'h0000_2222);
        wr(12'h02C, 32'h0000_0000);
        rdchk(12'h000, 32'h0000_CDAB);
        $display("test bank done");
        wr(12'h024, 32'h0000_AAAA);
        wr(12'h028, 32'h0000_5555);
        @(negedge clk);
        check(32'(activeStackPointer), 32'h0000_5555);
        wr(12'h02C, 32'h0000_0080);
        @(negedge clk);
        check(32'(activeStackPointer), 32'h0000_AAAA);
        dpm.spw(16'h0F0F);
        rdchk(12'h024, 32'h0000_0F0F);
        rdchk(12'h028, 32'h0000_5555);
        wr(12'h02C, 32'h0000_0000);
        $display("test stacks done");
        dpm.alu(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, CRS_SZ_WORD, 32'h0001_0000);
        @(negedge clk);
        check(32'(cpuStateFlags), 32'h0000_0025);
        dpm.alu(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, CRS_SZ_WORD, 32'h0000_8000);
        @(negedge clk);
        check(32'(cpuStateFlags), 32'h0000_0008);
        $display("test flags done");
        dpm.step(3'd3);
        dpm.step(3'd7);
        @(negedge clk);
        check(32'(nextFetchPointer), 32'h0000_000A);
        wr(12'h030, 32'h0000_0001);
        check(32'(err), 32'h0000_0001);
        rdchk(12'h030, 32'h0000_000A);
        dpm.dpw(CRS_SEL_PC, CRS_SZ_LONG, 1'b0, 32'h0000_FFFE);
        dpm.step(3'd3);
        rdchk(12'h030, 32'h0001_0001);
        $display("test counter done");
        apb(1'b0, 12'h040, 32'h0000_0000, 4'hF);
        check(rdat, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        wr(12'hFFC, 32'h0000_1111);
        check(32'(err), 32'h0000_0001);
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule : crs_register_set_bench
